/* File: mcs_pkg.sv */
// constants shared by the modem control supervisor
`default_nettype none
package mcs_pkg;
    // ========================================
    // clock and supervision tick
    localparam int CLK_MHZ         = 10;
    localparam int TICK_US         = 1000;
    localparam int TICK_CYCLES_DEF = TICK_US * CLK_MHZ;
    localparam int US_PER_MS       = 1000;
    // ========================================
    // supervision intervals; one extra tick absorbs the prescaler phase
    localparam int DSR_QUAL_MS     = 10;
    localparam int CD_LOSS_MS      = 1280;
    localparam int CTS_DROP_MS     = 10;
    localparam int CTS_TMO_MS      = 30000;
    localparam int DSR_QUAL_TICKS  = DSR_QUAL_MS * US_PER_MS / TICK_US + 1;
    localparam int CD_LOSS_TICKS   = CD_LOSS_MS * US_PER_MS / TICK_US + 1;
    localparam int CTS_DROP_TICKS  = CTS_DROP_MS * US_PER_MS / TICK_US + 1;
    localparam int CTS_TMO_TICKS   = CTS_TMO_MS * US_PER_MS / TICK_US + 1;
    // new signal pulse width
    localparam int NS_PULSE_US     = 10;
    localparam int NS_PULSE_CYC    = NS_PULSE_US * CLK_MHZ;
    localparam int NS_W            = $clog2(NS_PULSE_CYC + 1);
    // ========================================
    // register map (byte addresses)
    localparam int ADR_W           = 8;
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STAT = 8'h04;
    localparam logic [7:0] ADR_EVT  = 8'h08;
    localparam logic [7:0] ADR_MASK = 8'h0c;
    // control fields
    localparam int CTRL_DTR        = 0;
    localparam int CTRL_HDX        = 1;
    localparam int CTRL_START      = 2;
    localparam int CTRL_NEWSIG     = 3;
    localparam int CTRL_AA         = 4;
    // status fields
    localparam int ST_DSR          = 0;
    localparam int ST_CTS          = 1;
    localparam int ST_CD           = 2;
    localparam int ST_RING         = 3;
    localparam int ST_DTR          = 4;
    localparam int ST_RTS          = 5;
    localparam int ST_TXEN         = 6;
    localparam int ST_RXEN         = 7;
    localparam int ST_DSR_SEEN     = 8;
    // event fields
    localparam int EV_W            = 3;
    localparam int EV_DSR          = 0;
    localparam int EV_CD           = 1;
    localparam int EV_CTS          = 2;
    localparam logic [EV_W-1:0] EV_RST = 3'h0;
    // ========================================
    // request to send sequence
    typedef enum logic [1:0] {RS_IDLE, RS_CTS_WAIT, RS_ON} mcs_rts_type;
endpackage : mcs_pkg
`default_nettype wire

/* File: mcs_qual.sv */
// tick counter that qualifies a condition held for a number of ticks
`default_nettype none
module mcs_qual #(
    parameter int LIMIT = 10
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic tick_i,
    input  wire logic run_i,
    output logic      done_o
);
    localparam int CW = $clog2(LIMIT + 1);

    if (LIMIT < 1) begin : g_bad_limit
        $error("mcs_qual: LIMIT must be at least 1");
    end

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          done_r;
    logic          done_nxt;

    // ========================================
    // count ticks while the condition holds, one pulse on reaching limit
    always_comb begin
        cnt_nxt  = cnt_r;
        if (!run_i) begin
            cnt_nxt = '0;
        end else if (tick_i && cnt_r != CW'(LIMIT)) begin
            cnt_nxt = cnt_r + 1'b1;
        end
        done_nxt = run_i && (cnt_nxt == CW'(LIMIT)) && (cnt_r != CW'(LIMIT));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r  <= '0;
            done_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            done_r <= done_nxt;
        end
    end

    assign done_o = done_r;
endmodule : mcs_qual
`default_nettype wire

/* File: mcs_top.sv */
// modem control supervisor with wishbone register slave
// Notes on behaviour
// R1 - assert terminal ready when ready; hold it while the connection is wanted
// R2 - modem drops the line on terminal ready off, after sending pending data
// R3 - modem may read terminal ready off as power loss or cable fault
// R4 - pulse new signal briefly before a new tributary message begins
// R5 - modem resets receive timing recovery on the new signal pulse
// R6 - in half duplex, block reception while transmission is in progress
// R7 - once modem ready seen, report every later fall as disconnect event
// R8 - modem ready counts as dropped only after a full qualified low interval
// R9 - transmit starts inhibited; allowed only with modem ready and rts/cts handshake
// R10 - carrier low longer than loss interval raises a carrier loss event
// R11 - each supervision sequence runs concurrently and independently
// R12 - host reads modem leads and writes control leads through registers
// R13 - on qualified ready drop, resync tx/rx, idle them, then drop terminal ready; the code raises line reset and drops terminal ready in the same cycle
// R14 - before rts, wait bounded time for cts to drop, else assume constant
// R15 - cts not returned in timeout: disconnect event, reset tx/rx, drop terminal ready
// R16 - all timers derive from the controller clock through a fine tick; the new signal pulse counts controller clocks directly
//
// The register addresses and register access over Wishbone were left to the implementer.
`default_nettype none
module mcs_top
    import mcs_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // wishbone slave
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    input  wire logic             we_i,
    input  wire logic [ADR_W-1:0] adr_i,
    input  wire logic [3:0]       sel_i,
    input  wire logic [31:0]      dat_i,
    output logic [31:0]           dat_o,
    output logic                  ack_o,
    output logic                  irq_o,
    // modem leads
    input  wire logic             dsr_i,
    input  wire logic             cts_i,
    input  wire logic             cd_i,
    input  wire logic             ring_i,
    output logic                  dtr_o,
    output logic                  rts_o,
    output logic                  new_sig_o,
    // line unit side
    input  wire logic             tx_active_i,
    output logic                  tx_enable_o,
    output logic                  rx_enable_o,
    output logic                  line_reset_o
);
    localparam int TW = $clog2(TICK_CYCLES);

    if (TICK_CYCLES < 2) begin : g_bad_tick
        $error("mcs_top: TICK_CYCLES must be at least 2");
    end

    // ========================================
    // supervision tick prescaler
    logic [TW-1:0] tick_cnt_r;
    logic [TW-1:0] tick_cnt_nxt;
    logic          tick_r;
    logic          tick_nxt;

    // one tick pulse per TICK_CYCLES clocks
    always_comb begin
        tick_nxt     = (tick_cnt_r == TW'(TICK_CYCLES - 1)); // R16
        tick_cnt_nxt = tick_nxt ? '0 : tick_cnt_r + 1'b1;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tick_cnt_r <= '0;
            tick_r     <= 1'b0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            tick_r     <= tick_nxt;
        end
    end

    // ========================================
    // state
    logic            dtr_r, dtr_nxt;
    logic            rts_r, rts_nxt;
    logic            dsr_seen_r, dsr_seen_nxt;
    logic            cd_seen_r, cd_seen_nxt;
    logic            txen_r, txen_nxt;
    logic            rxen_r, rxen_nxt;
    logic            lres_r, lres_nxt;
    logic            hdx_r, hdx_nxt;
    logic            start_r, start_nxt;
    logic            aa_r, aa_nxt;
    logic [NS_W-1:0] ns_cnt_r, ns_cnt_nxt;
    logic            ns_r, ns_nxt;
    logic [EV_W-1:0] ev_r, ev_nxt;
    logic [EV_W-1:0] mask_r, mask_nxt;
    logic            irq_r, irq_nxt;
    logic            ack_r, ack_nxt;
    logic [31:0]     dat_r, dat_nxt;
    mcs_rts_type     rs_r, rs_nxt;
    logic            dsr_done, cd_done, ctsw_done, ctst_done;
    logic            fault;
    logic            wr;
    logic [EV_W-1:0] ev_set;

    // ========================================
    // independent qualification timers
    mcs_qual #(.LIMIT(DSR_QUAL_TICKS)) u_dsr (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_i (tick_r),
        .run_i  (dsr_seen_r && !dsr_i), // R8 R11
        .done_o (dsr_done)
    );
    mcs_qual #(.LIMIT(CD_LOSS_TICKS)) u_cd (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_i (tick_r),
        .run_i  (cd_seen_r && !cd_i), // R10 R11
        .done_o (cd_done)
    );
    mcs_qual #(.LIMIT(CTS_DROP_TICKS)) u_ctsw (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_i (tick_r),
        .run_i  (rs_r == RS_CTS_WAIT), // R14
        .done_o (ctsw_done)
    );
    mcs_qual #(.LIMIT(CTS_TMO_TICKS)) u_ctst (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .tick_i (tick_r),
        .run_i  (rs_r == RS_ON && !cts_i), // R15
        .done_o (ctst_done)
    );

    assign fault  = dsr_done || ctst_done;
    assign wr     = cyc_i && stb_i && we_i && ack_r && sel_i[0];
    assign ev_set = {ctst_done, cd_done, dsr_done}; // R7 R10 R15

    // ========================================
    // lead supervision next state
    always_comb begin
        dtr_nxt      = dtr_r;
        hdx_nxt      = hdx_r;
        start_nxt    = start_r;
        aa_nxt       = aa_r;
        rs_nxt       = rs_r;
        ns_cnt_nxt   = ns_cnt_r;
        dsr_seen_nxt = dsr_seen_r || dsr_i;
        cd_seen_nxt  = cd_seen_r || cd_i;
        if (dsr_done) begin
            dsr_seen_nxt = 1'b0; // R7
        end
        if (cd_done) begin
            cd_seen_nxt = 1'b0;
        end
        // host control writes
        if (wr && adr_i == ADR_CTRL) begin
            dtr_nxt   = dat_i[CTRL_DTR]; // R1 R12
            hdx_nxt   = dat_i[CTRL_HDX];
            start_nxt = dat_i[CTRL_START];
            aa_nxt    = dat_i[CTRL_AA];
            if (dat_i[CTRL_NEWSIG]) begin
                ns_cnt_nxt = NS_W'(NS_PULSE_CYC); // R4
            end
        end else if (ns_cnt_r != '0) begin
            ns_cnt_nxt = ns_cnt_r - 1'b1;
        end
        // auto answer raises terminal ready on ring
        if (aa_r && ring_i) begin
            dtr_nxt = 1'b1; // R1
        end
        // request to send sequence
        case (rs_r)
            RS_IDLE: begin
                if (start_r && dtr_r && dsr_i) begin
                    rs_nxt = cts_i ? RS_CTS_WAIT : RS_ON; // R14
                end
            end
            RS_CTS_WAIT: begin
                if (!cts_i || ctsw_done) begin
                    rs_nxt = RS_ON; // R14
                end
                if (!start_r || !dtr_r) begin
                    rs_nxt = RS_IDLE;
                end
            end
            RS_ON: begin
                if (!start_r || !dtr_r) begin
                    rs_nxt = RS_IDLE;
                end
            end
            default: rs_nxt = RS_IDLE;
        endcase
        // disconnect: resync line, idle sequences, drop terminal ready
        if (fault) begin
            rs_nxt    = RS_IDLE; // R13 R15
            start_nxt = 1'b0;
            dtr_nxt   = 1'b0; // R13 R15
        end
        rts_nxt  = (rs_nxt == RS_ON);
        lres_nxt = fault; // R13 R15
        txen_nxt = rts_r && dtr_r && dsr_seen_r && dsr_i && cts_i && !fault; // R9
        rxen_nxt = dtr_r && !(hdx_r && (tx_active_i || txen_r)); // R6
        ns_nxt   = (ns_cnt_nxt != '0); // R4
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dtr_r      <= 1'b0;
            rts_r      <= 1'b0;
            dsr_seen_r <= 1'b0;
            cd_seen_r  <= 1'b0;
            txen_r     <= 1'b0;
            rxen_r     <= 1'b0;
            lres_r     <= 1'b0;
            hdx_r      <= 1'b0;
            start_r    <= 1'b0;
            aa_r       <= 1'b0;
            ns_cnt_r   <= '0;
            ns_r       <= 1'b0;
            rs_r       <= RS_IDLE;
        end else begin
            dtr_r      <= dtr_nxt;
            rts_r      <= rts_nxt;
            dsr_seen_r <= dsr_seen_nxt;
            cd_seen_r  <= cd_seen_nxt;
            txen_r     <= txen_nxt;
            rxen_r     <= rxen_nxt;
            lres_r     <= lres_nxt;
            hdx_r      <= hdx_nxt;
            start_r    <= start_nxt;
            aa_r       <= aa_nxt;
            ns_cnt_r   <= ns_cnt_nxt;
            ns_r       <= ns_nxt;
            rs_r       <= rs_nxt;
        end
    end

    // ========================================
    // bus slave, events and interrupt next state
    always_comb begin
        ack_nxt  = cyc_i && stb_i && !ack_r;
        dat_nxt  = dat_r;
        ev_nxt   = ev_r;
        mask_nxt = mask_r;
        if (wr && adr_i == ADR_EVT) begin
            ev_nxt = ev_r & ~dat_i[EV_W-1:0];
        end
        if (wr && adr_i == ADR_MASK) begin
            mask_nxt = dat_i[EV_W-1:0];
        end
        ev_nxt  = ev_nxt | ev_set; // set wins over clear
        irq_nxt = |(ev_nxt & mask_nxt);
        if (ack_nxt) begin
            dat_nxt = '0; // unmapped reads zero
            case (adr_i)
                ADR_CTRL: begin
                    dat_nxt[CTRL_DTR]   = dtr_r;
                    dat_nxt[CTRL_HDX]   = hdx_r;
                    dat_nxt[CTRL_START] = start_r;
                    dat_nxt[CTRL_AA]    = aa_r;
                end
                ADR_STAT: begin
                    dat_nxt[ST_DSR]      = dsr_i; // R12
                    dat_nxt[ST_CTS]      = cts_i;
                    dat_nxt[ST_CD]       = cd_i;
                    dat_nxt[ST_RING]     = ring_i;
                    dat_nxt[ST_DTR]      = dtr_r;
                    dat_nxt[ST_RTS]      = rts_r;
                    dat_nxt[ST_TXEN]     = txen_r;
                    dat_nxt[ST_RXEN]     = rxen_r;
                    dat_nxt[ST_DSR_SEEN] = dsr_seen_r;
                end
                ADR_EVT:  dat_nxt[EV_W-1:0] = ev_r;
                ADR_MASK: dat_nxt[EV_W-1:0] = mask_r;
                default:  dat_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r  <= 1'b0;
            dat_r  <= '0;
            ev_r   <= EV_RST;
            mask_r <= EV_RST;
            irq_r  <= 1'b0;
        end else begin
            ack_r  <= ack_nxt;
            dat_r  <= dat_nxt;
            ev_r   <= ev_nxt;
            mask_r <= mask_nxt;
            irq_r  <= irq_nxt;
        end
    end

    // ========================================
    // outputs
    assign dat_o        = dat_r;
    assign ack_o        = ack_r;
    assign irq_o        = irq_r;
    assign dtr_o        = dtr_r;
    assign rts_o        = rts_r;
    assign new_sig_o    = ns_r;
    assign tx_enable_o  = txen_r;
    assign rx_enable_o  = rxen_r;
    assign line_reset_o = lres_r;

    // ========================================
    // checks
    int dsr_low_cnt;
    int cd_low_cnt;
    always_ff @(posedge clk_i) begin
        dsr_low_cnt <= (rst_i || dsr_i) ? 0 : dsr_low_cnt + 1;
        cd_low_cnt  <= (rst_i || cd_i) ? 0 : cd_low_cnt + 1;
    end

    chk_hdx_rx_block: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        hdx_r && tx_active_i |=> !rx_enable_o) else $error("rx enabled during half duplex tx");
    chk_tx_gate_leads: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        tx_enable_o |-> $past(rts_o && dtr_o && dsr_i && cts_i)) else $error("tx enabled without handshake");
    chk_dsr_qual_time: assert property (@(posedge clk_i) disable iff (rst_i) // R8
        dsr_done |-> dsr_low_cnt >= (DSR_QUAL_TICKS - 1) * TICK_CYCLES) else $error("ready drop too early");
    chk_dsr_drop_event: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        dsr_done |=> ev_r[EV_DSR]) else $error("ready drop not reported");
    chk_drop_dtr_off: assert property (@(posedge clk_i) disable iff (rst_i) // R13
        dsr_done |=> line_reset_o && !dtr_o && !rts_o) else $error("drop did not clear line");
    chk_cd_loss_time: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        cd_done |-> cd_low_cnt >= (CD_LOSS_TICKS - 1) * TICK_CYCLES ##1 ev_r[EV_CD]) else $error("carrier loss");
    chk_cts_fail_clear: assert property (@(posedge clk_i) disable iff (rst_i) // R15
        ctst_done |=> ev_r[EV_CTS] && !dtr_o && line_reset_o) else $error("cts failure not handled");
    chk_dtr_hold_fall: assert property (@(posedge clk_i) disable iff (rst_i) // R1
        $fell(dtr_o) |-> $past(fault || wr)) else $error("terminal ready fell unasked");
    chk_new_sig_width: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        $rose(new_sig_o) |-> new_sig_o [*8]) else $error("new signal pulse too short");
    chk_rts_cts_wait: assert property (@(posedge clk_i) disable iff (rst_i) // R14
        $rose(rts_o) |-> $past(!cts_i || ctsw_done)) else $error("rts raised early");
    chk_irq_cause: assert property (@(posedge clk_i) disable iff (rst_i)
        irq_o |-> |(ev_r & mask_r)) else $error("interrupt without cause");

    cov_dsr_drop: cover property (@(posedge clk_i) disable iff (rst_i) dsr_done);
    cov_cts_fail: cover property (@(posedge clk_i) disable iff (rst_i) ctst_done);
    cov_tx_on: cover property (@(posedge clk_i) disable iff (rst_i) $rose(tx_enable_o));
    cov_cd_loss: cover property (@(posedge clk_i) disable iff (rst_i) cd_done);
endmodule : mcs_top
`default_nettype wire

/* File: mcs_modem_model.sv */
// behavioural modem answering the supervisor's control leads
`default_nettype none
module mcs_modem_model (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       dtr_i,
    input  wire logic       rts_i,
    input  wire logic       new_sig_i,
    input  wire logic       line_up_i,
    input  wire logic       carrier_i,
    input  wire logic       cts_const_i,
    input  wire logic       ring_req_i,
    input  wire logic [7:0] cts_dly_i,
    output logic            dsr_o,
    output logic            cts_o,
    output logic            cd_o,
    output logic            ring_o,
    output logic            resync_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_r;
    // ========================================
    // line hold, carrier and clear to send
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dsr_o <= 1'b0;
            cts_o <= 1'b0;
            cd_o  <= 1'b0;
            cnt_r <= 8'h00;
        end else begin
            dsr_o <= dtr_i & line_up_i;
            cd_o  <= dtr_i & carrier_i;
            if (cts_const_i) begin
                cts_o <= 1'b1;
            end else if (rts_i && cnt_r >= cts_dly_i && cts_dly_i != 8'hff) begin // all ones: never answers
                cts_o <= 1'b1;
            end else begin
                cts_o <= 1'b0;
                cnt_r <= rts_i ? cnt_r + 8'h01 : 8'h00;
            end
        end
    end
    // ring lead and receive timing recovery reset
    always_ff @(posedge clk_i) begin
        ring_o   <= ring_req_i;
        resync_o <= new_sig_i;
    end
endmodule : mcs_modem_model
`default_nettype wire

/* File: mcs_top_tb.sv */
// self-checking bench for the modem control supervisor
`default_nettype none
module mcs_top_tb
    import mcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TCK   = 2;
    localparam int LIMIT = 75000;
    logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, tx_active = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [3:0]  sel = 4'h0;
    logic [31:0] dat_w = 32'h0, dat_r;
    logic        ack, irq, dsr, cts, cd, ring, dtr, rts, new_sig, tx_en, rx_en, line_reset, resync;
    logic        line_up = 1'b1, carrier = 1'b1, cts_const = 1'b0, ring_req = 1'b0;
    logic [7:0]  cts_dly = 8'h06;
    int          fails = 0, checks_done = 0, cycles = 0, n, k;

    mcs_top #(.TICK_CYCLES(TCK)) mcs_top_i (
        .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .irq_o(irq), .dsr_i(dsr), .cts_i(cts), .cd_i(cd),
        .ring_i(ring), .dtr_o(dtr), .rts_o(rts), .new_sig_o(new_sig), .tx_active_i(tx_active),
        .tx_enable_o(tx_en), .rx_enable_o(rx_en), .line_reset_o(line_reset));
    mcs_modem_model mcs_modem_model_i (
        .clk_i(clk), .rst_i(rst), .dtr_i(dtr), .rts_i(rts), .new_sig_i(new_sig), .line_up_i(line_up),
        .carrier_i(carrier), .cts_const_i(cts_const), .ring_req_i(ring_req), .cts_dly_i(cts_dly),
        .dsr_o(dsr), .cts_o(cts), .cd_o(cd), .ring_o(ring), .resync_o(resync));

    // ========================================
    // clock and hang guard
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            fails = fails + 1;
            print_verdict();
        end
    end

    // ========================================
    // compare, bus and report tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int m;
        m = 0;
        @(posedge clk);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        sel   <= 4'h1;
        dat_w <= d;
        // request stands until ack is sampled high at a rising edge
        do begin
            @(posedge clk);
            m++;
        end while (ack !== 1'b1);
        check(32'(m), 32'h2);
        q = dat_r;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] msk = 32'hffff_ffff);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        check(q & msk, e);
    endtask : rdc
    task automatic print_verdict();
        $display("checks=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    // ========================================
    // scenarios
    task automatic t_reset();
        @(negedge clk);
        check(32'({dtr, rts, tx_en, rx_en, new_sig, line_reset, irq}), 32'h0);
        rdc(ADR_CTRL, 32'h0);
        wr(8'h10, 32'hff);
        rdc(8'h10, 32'h0);
        rdc(ADR_CTRL, 32'h0);
        rdc(ADR_EVT, 32'h0);
        $display("reset done");
    endtask : t_reset
    task automatic t_start();
        wr(ADR_CTRL, 32'h05);
        @(negedge clk);
        check(32'({dtr, tx_en}), 32'h2);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (tx_en !== 1'b1 && n < 40);
        check(32'({cts, rts, tx_en}), 32'h7);
        rdc(ADR_STAT, 32'h177, 32'h17f);
        rdc(ADR_CTRL, 32'h05);
        $display("start done");
    endtask : t_start
    task automatic t_halfdup();
        wr(ADR_CTRL, 32'h07);
        @(posedge clk);
        tx_active <= 1'b1;
        repeat (3) @(negedge clk);
        check(32'({rx_en, tx_en}), 32'h1);
        @(posedge clk);
        tx_active <= 1'b0;
        wr(ADR_CTRL, 32'h05);
        $display("half duplex done");
    endtask : t_halfdup
    task automatic t_newsig();
        wr(ADR_CTRL, 32'h0d);
        k = 0;
        n = 0;
        while (new_sig !== 1'b1 && k < 10) begin
            @(negedge clk);
            k++;
        end
        while (new_sig === 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        check(n, NS_PULSE_CYC);
        check(32'({resync, new_sig}), 32'h2);
        rdc(ADR_CTRL, 32'h05);
        $display("new signal done");
    endtask : t_newsig
    task automatic t_dsr();
        wr(ADR_MASK, 32'h01);
        @(posedge clk);
        line_up <= 1'b0;
        repeat (10) @(posedge clk);
        line_up <= 1'b1;
        repeat (60) @(negedge clk);
        check(32'(dtr), 32'h1);
        rdc(ADR_EVT, 32'h0);
        @(posedge clk);
        line_up <= 1'b0;
        n = 0;
        k = 0;
        do begin
            @(negedge clk);
            n++;
            if (line_reset === 1'b1 && k == 0) begin
                k = n;
            end
        end while (dtr === 1'b1 && n < 100);
        check(32'(n >= 21 && n <= 30), 32'h1);
        check(32'(k > 0 && k <= n), 32'h1);
        rdc(ADR_EVT, 32'h01);
        check(32'({irq, rts}), 32'h2);
        rdc(ADR_CTRL, 32'h0);
        wr(ADR_EVT, 32'h01);
        @(negedge clk);
        check(32'(irq), 32'h0);
        $display("ready drop done");
    endtask : t_dsr
    task automatic t_cts_const();
        @(posedge clk);
        line_up   <= 1'b1;
        cts_const <= 1'b1;
        wr(ADR_CTRL, 32'h05);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (rts !== 1'b1 && n < 100);
        check(32'(n >= 21 && n <= 34), 32'h1);
        @(negedge clk);
        check(32'(tx_en), 32'h1);
        $display("constant cts done");
    endtask : t_cts_const
    task automatic t_carrier();
        wr(ADR_MASK, 32'h00);
        @(posedge clk);
        carrier <= 1'b0;
        repeat (2556) @(posedge clk);
        rdc(ADR_EVT, 32'h0);
        repeat (40) @(posedge clk);
        rdc(ADR_EVT, 32'h02);
        check(32'({irq, dtr, tx_en}), 32'h3);
        wr(ADR_MASK, 32'h02);
        @(negedge clk);
        check(32'(irq), 32'h1);
        wr(ADR_EVT, 32'h02);
        @(negedge clk);
        check(32'(irq), 32'h0);
        @(posedge clk);
        carrier <= 1'b1;
        $display("carrier loss done");
    endtask : t_carrier
    task automatic t_ring();
        wr(ADR_CTRL, 32'h00);
        @(negedge clk);
        check(32'(dtr), 32'h0);
        wr(ADR_CTRL, 32'h10);
        @(posedge clk);
        ring_req <= 1'b1;
        repeat (6) @(negedge clk);
        check(32'(dtr), 32'h1);
        $display("auto answer done");
    endtask : t_ring
    task automatic t_cts_fail();
        @(posedge clk);
        ring_req  <= 1'b0;
        cts_const <= 1'b0;
        cts_dly   <= 8'hff;
        wr(ADR_MASK, 32'h04);
        wr(ADR_CTRL, 32'h05);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (dtr === 1'b1 && n < 65000);
        check(32'(n > (CTS_TMO_TICKS - 1) * TCK && n <= (CTS_TMO_TICKS + 1) * TCK + 2), 32'h1);
        check(32'({irq, dtr, rts, tx_en, line_reset}), 32'h11);
        rdc(ADR_EVT, 32'h04);
        wr(ADR_EVT, 32'h04);
        @(negedge clk);
        check(32'(irq), 32'h0);
        $display("cts failure done");
    endtask : t_cts_fail

    // ========================================
    // main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_start();
        t_halfdup();
        t_newsig();
        t_dsr();
        t_cts_const();
        t_carrier();
        t_ring();
        t_cts_fail();
        print_verdict();
    end
endmodule : mcs_top_tb
`default_nettype wire
